// *** src/vpen_pkg.sv ***
// Purpose: Shared constants and types for the virtual processor enable unit
// Assumes: 32-bit instruction words, APB register window with 12-bit offsets
// Notes:   Event bit positions are shared by the status and mask registers
package vpen_pkg;
   // Instruction encoding fields
   localparam logic [5:0]  OPC_MAJOR     = 6'h00;
   localparam logic [4:0]  OPC_ZERO      = 5'h00;
   localparam logic [9:0]  OPC_MINOR     = 10'h0e5;
   localparam logic [5:0]  OPC_GROUP     = 6'h3c;
   localparam logic [3:0]  MIN_REV       = 4'h6;
   // Register byte offsets
   localparam logic [11:0] ADDR_CTRL     = 12'h000;
   localparam logic [11:0] ADDR_VPCTL    = 12'h004;
   localparam logic [11:0] ADDR_STATUS   = 12'h008;
   localparam logic [11:0] ADDR_MASK     = 12'h00c;
   localparam logic [11:0] ADDR_VPSTATE  = 12'h010;
   // Control register fields and reset value
   localparam int          CTRL_MT_BIT   = 0;
   localparam int          CTRL_REV_LSB  = 4;
   localparam logic [31:0] CTRL_RST      = 32'h0000_0061;
   localparam logic [31:0] CTRL_WMASK    = 32'h0000_00f1;
   // Control word field
   localparam int          HALT_BIT      = 0;
   // Event bits
   localparam int          EV_W          = 5;
   localparam int          EV_DONE       = 0;
   localparam int          EV_NOP        = 1;
   localparam int          EV_CU         = 2;
   localparam int          EV_RI         = 3;
   localparam int          EV_STOP       = 4;
   localparam logic [4:0]  MASK_RST      = 5'h00;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_EXEC  = 4'b0010,
      ST_WAKE  = 4'b0100,
      ST_CLEAR = 4'b1000
   } vpen_state_t;

   typedef struct packed {
      logic [31:0] instr;
      logic        oldest;
      logic        speculative;
      logic        cop0_ok;
   } vpen_req_t;

   typedef struct packed {
      logic        gpr_we;
      logic [4:0]  gpr_addr;
      logic [31:0] gpr_data;
      logic        exc_cu;
      logic        exc_ri;
      logic        nop;
   } vpen_resp_t;
endpackage : vpen_pkg

// *** src/vpen_unit.sv ***
// Purpose: Executes the enable-virtual-processors instruction for one core
// Assumes: Requests arrive from the issuing processor's retire stage
// Notes:   Halted flag is core-wide; disable pulses come from outside
// Contract
// - Decode major 000000, zero 25..21, source field 20..16, minor 0011100101, 111100.
// - On effect, resume fetch on every virtual processor except the issuer.
// - Clear the halted flag only after all others are re-enabled.
// - Copy the control word to the source register first when field is non-zero.
// - Take effect only while the halted flag is one, else no-operation.
// - Never speculative; take effect only as the oldest unretired instruction.
// - Without multithreading present, execute as a no-operation.
// - System coprocessor access disabled raises a coprocessor-unusable exception.
// - Architecture revision below 6 raises a reserved-instruction exception.
// - Other processors resume at once, state restored as before the disable.
// - State lost between disable and enable gives no guaranteed effect.
// - Paused processor with link flag cleared before enable stays stopped.
// - Processor waiting at disable ignores interrupts until the enable.
`timescale 1ns/1ps
`default_nettype none
module vpen_unit #(
   parameter int NVP = 4,
   parameter int VPW = 2
) (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [11:0]        paddr,
   input  wire logic [31:0]        pwdata,
   output logic [31:0]             prdata,
   output logic                    pready,
   output logic                    pslverr,
   output logic                    irq,
   input  wire vpen_pkg::vpen_req_t req,
   input  wire logic [VPW-1:0]     req_issuer,
   input  wire logic               req_valid,
   output logic                    req_ready,
   output vpen_pkg::vpen_resp_t    resp,
   output logic                    resp_valid,
   input  wire logic               dvp_set,
   input  wire logic [VPW-1:0]     dvp_issuer,
   input  wire logic [NVP-1:0]     pause_retired,
   input  wire logic [NVP-1:0]     wait_retired,
   input  wire logic [NVP-1:0]     load_link_flag,
   output logic [NVP-1:0]          fetch_en,
   output logic [NVP-1:0]          irq_en,
   output logic                    halted_flag
);
   // Instruction match on every fixed field
   function automatic logic is_enable_op(input logic [31:0] w);
      is_enable_op = (w[31:26] == vpen_pkg::OPC_MAJOR) && (w[25:21] == vpen_pkg::OPC_ZERO) &&
                     (w[15:6] == vpen_pkg::OPC_MINOR) && (w[5:0] == vpen_pkg::OPC_GROUP);
   endfunction : is_enable_op

   // Mask with a one for every processor except the given one
   function automatic logic [NVP-1:0] others(input logic [VPW-1:0] id);
      others = ~(NVP'(1) << id);
   endfunction : others

   vpen_pkg::vpen_state_t state;
   logic [31:0]           ctrl;
   logic [vpen_pkg::EV_W-1:0] status;
   logic [vpen_pkg::EV_W-1:0] mask;
   logic [vpen_pkg::EV_W-1:0] ev;
   logic [vpen_pkg::EV_W-1:0] rd_clr;
   logic [31:0]           instr_q;
   logic [VPW-1:0]        issuer_q;
   logic                  cop0_q;
   logic                  rev_ok;
   logic                  mt_on;
   logic                  go;
   logic                  take;
   logic [NVP-1:0]        stay_mask;
   logic [31:0]           vpctl_word;
   logic                  wr_acc;
   logic                  rd_acc;
   logic                  setup;

   assign mt_on      = ctrl[vpen_pkg::CTRL_MT_BIT];
   assign rev_ok     = ctrl[vpen_pkg::CTRL_REV_LSB +: 4] >= vpen_pkg::MIN_REV;
   assign vpctl_word = {31'h0000_0000, halted_flag};
   // Effect only when flag set and threading present
   assign go         = mt_on && halted_flag;
   // Paused processors whose link flag already dropped stay stopped
   assign stay_mask  = pause_retired & ~load_link_flag;

   // Accept only a decoded, oldest, non-speculative request while idle
   assign req_ready = (state == vpen_pkg::ST_IDLE) && is_enable_op(req.instr) &&
                      req.oldest && !req.speculative;
   assign take      = req_valid && req_ready;

   // Sequencer: decode, wake others, then clear the halted flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= vpen_pkg::ST_IDLE;
      end else begin
         case (state)
            vpen_pkg::ST_IDLE: begin
               if (take) begin
                  state <= vpen_pkg::ST_EXEC;
               end
            end
            vpen_pkg::ST_EXEC: begin
               if (rev_ok && cop0_q && go) begin
                  state <= vpen_pkg::ST_WAKE;
               end else begin
                  state <= vpen_pkg::ST_IDLE;
               end
            end
            vpen_pkg::ST_WAKE: begin
               state <= vpen_pkg::ST_CLEAR;
            end
            vpen_pkg::ST_CLEAR: begin
               state <= vpen_pkg::ST_IDLE;
            end
            default: begin
               state <= vpen_pkg::ST_IDLE;
            end
         endcase
      end
   end

   // Request capture
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         instr_q  <= 32'h0000_0000;
         issuer_q <= '0;
         cop0_q   <= 1'b0;
      end else if (take) begin
         instr_q  <= req.instr;
         issuer_q <= req_issuer;
         cop0_q   <= req.cop0_ok;
      end
   end

   // Answer: exceptions, no-operation, or register copy of the old word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         resp       <= '0;
         resp_valid <= 1'b0;
      end else begin
         resp_valid <= 1'b0;
         if (state == vpen_pkg::ST_EXEC) begin
            resp          <= '0;
            resp.gpr_addr <= instr_q[20:16];
            resp.gpr_data <= vpctl_word;
            if (!rev_ok) begin
               resp.exc_ri <= 1'b1;
               resp_valid  <= 1'b1;
            end else if (!cop0_q) begin
               resp.exc_cu <= 1'b1;
               resp_valid  <= 1'b1;
            end else begin
               resp.gpr_we <= instr_q[20:16] != 5'h00;
               resp.nop    <= !go;
               resp_valid  <= !go;
            end
         end else if (state == vpen_pkg::ST_CLEAR) begin
            resp_valid <= 1'b1;
         end
      end
   end

   // Core-wide halted flag; a disable in the clear cycle wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         halted_flag <= 1'b0;
      end else if (dvp_set) begin
         halted_flag <= 1'b1;
      end else if (state == vpen_pkg::ST_CLEAR) begin
         halted_flag <= 1'b0;
      end
   end

   // Fetch enables: stop others on disable, resume at once on enable
   // Lost processor state between the pair is not repaired here
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fetch_en <= '1;
      end else if (dvp_set) begin
         fetch_en <= fetch_en & ~others(dvp_issuer);
      end else if (state == vpen_pkg::ST_WAKE) begin
         fetch_en <= fetch_en | (others(issuer_q) & ~stay_mask);
      end
   end

   // Interrupt enables: waiting processors go deaf until the enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_en <= '1;
      end else if (dvp_set) begin
         irq_en <= irq_en & ~(others(dvp_issuer) & wait_retired);
      end else if (state == vpen_pkg::ST_WAKE) begin
         irq_en <= irq_en | others(issuer_q);
      end
   end

   // Event pulses
   always_comb begin
      ev                    = '0;
      ev[vpen_pkg::EV_DONE] = state == vpen_pkg::ST_CLEAR;
      ev[vpen_pkg::EV_NOP]  = resp_valid && resp.nop;
      ev[vpen_pkg::EV_CU]   = resp_valid && resp.exc_cu;
      ev[vpen_pkg::EV_RI]   = resp_valid && resp.exc_ri;
      ev[vpen_pkg::EV_STOP] = dvp_set;
   end

   // APB phases; zero wait states
   assign setup   = psel && !penable;
   assign wr_acc  = psel && penable && pwrite;
   assign rd_acc  = psel && penable && !pwrite;
   assign pready  = 1'b1;
   assign rd_clr  = (rd_acc && paddr == vpen_pkg::ADDR_STATUS) ?
                    prdata[vpen_pkg::EV_W-1:0] : '0;

   // Read data captured in setup so the access cycle returns a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (setup) begin
         pslverr <= 1'b0;
         if (paddr == vpen_pkg::ADDR_CTRL) begin
            prdata <= ctrl;
         end else if (paddr == vpen_pkg::ADDR_VPCTL) begin
            prdata <= vpctl_word;
         end else if (paddr == vpen_pkg::ADDR_STATUS) begin
            prdata <= {27'h000_0000, status};
         end else if (paddr == vpen_pkg::ADDR_MASK) begin
            prdata <= {27'h000_0000, mask};
         end else if (paddr == vpen_pkg::ADDR_VPSTATE) begin
            prdata <= {16'h0000, 8'(irq_en), 8'(fetch_en)};
         end else begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b1;
         end
      end
   end

   // Writable configuration
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= vpen_pkg::CTRL_RST;
         mask <= vpen_pkg::MASK_RST;
      end else if (wr_acc) begin
         if (paddr == vpen_pkg::ADDR_CTRL) begin
            ctrl <= pwdata & vpen_pkg::CTRL_WMASK;
         end else if (paddr == vpen_pkg::ADDR_MASK) begin
            mask <= pwdata[vpen_pkg::EV_W-1:0];
         end
      end
   end

   // Sticky status; clears only bits that were read, new events win
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= '0;
      end else begin
         status <= (status & ~rd_clr) | ev;
      end
   end

   assign irq = |(status & mask);

   // Checks
   logic [VPW-1:0] iss_chk;
   assign iss_chk = issuer_q;

   // Decode and ordering; fields checked one by one, apart from the match function
   decode_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
      take |-> req.instr[31:26] == vpen_pkg::OPC_MAJOR &&
      req.instr[25:21] == vpen_pkg::OPC_ZERO && req.instr[15:6] == vpen_pkg::OPC_MINOR &&
      req.instr[5:0] == vpen_pkg::OPC_GROUP)
      else $error("accepted a non-matching encoding");
   oldest_only_a: assert property (@(posedge pclk) disable iff (!presetn)
      take |-> req.oldest && !req.speculative)
      else $error("accepted a young or speculative request");

   // Wake before clear
   wake_others_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state == vpen_pkg::ST_WAKE && !dvp_set) |=>
      ((fetch_en & others(iss_chk) & ~$past(stay_mask)) == (others(iss_chk) & ~$past(stay_mask))))
      else $error("other processors not resumed");
   clear_late_a: assert property (@(posedge pclk) disable iff (!presetn)
      (halted_flag && !dvp_set ##1 !halted_flag) |-> $past(state, 1) == vpen_pkg::ST_CLEAR &&
      $past(state, 2) == vpen_pkg::ST_WAKE)
      else $error("halted flag cleared before wake");

   // Answer codes, then paused and waiting processors and the halted flag
   gpr_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state == vpen_pkg::ST_EXEC && rev_ok && cop0_q) |=>
      resp.gpr_we == (resp.gpr_addr != 5'h00) && resp.gpr_data == $past(vpctl_word))
      else $error("old control word not returned");
   nop_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state == vpen_pkg::ST_EXEC && rev_ok && cop0_q && !halted_flag) |=>
      resp_valid && resp.nop && state == vpen_pkg::ST_IDLE)
      else $error("enable took effect while not halted");
   mt_nop_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state == vpen_pkg::ST_EXEC && rev_ok && cop0_q && !mt_on) |=>
      resp.nop && $stable(fetch_en))
      else $error("enable acted without multithreading");
   cu_exc_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state == vpen_pkg::ST_EXEC && rev_ok && !cop0_q) |=>
      resp_valid && resp.exc_cu && !resp.gpr_we)
      else $error("missing coprocessor-unusable exception");
   ri_exc_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state == vpen_pkg::ST_EXEC && !rev_ok) |=> resp_valid && resp.exc_ri && !resp.exc_cu)
      else $error("missing reserved-instruction exception");
   pause_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state == vpen_pkg::ST_WAKE && !dvp_set) |=>
      (fetch_en & $past(stay_mask)) == ($past(fetch_en) & $past(stay_mask)))
      else $error("paused processor resumed after link clear");
   wait_deaf_a: assert property (@(posedge pclk) disable iff (!presetn)
      dvp_set |=> (irq_en & others($past(dvp_issuer)) & $past(wait_retired)) == '0)
      else $error("waiting processor still takes interrupts");
   halt_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      dvp_set |=> halted_flag)
      else $error("disable did not set halted flag");

   // Flags and enables change only on a disable or inside the enable sequence
   halt_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!dvp_set && state != vpen_pkg::ST_CLEAR) |=> $stable(halted_flag))
      else $error("halted flag changed with no cause");
   fetch_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!dvp_set && state != vpen_pkg::ST_WAKE) |=> $stable(fetch_en))
      else $error("fetch enables changed with no cause");
   irq_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      (!dvp_set && state != vpen_pkg::ST_WAKE) |=> $stable(irq_en))
      else $error("interrupt enables changed with no cause");
   issuer_kept_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state == vpen_pkg::ST_WAKE && !dvp_set) |=>
      fetch_en[iss_chk] == $past(fetch_en[iss_chk]))
      else $error("issuer fetch enable touched by its own enable");
   done_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      (state == vpen_pkg::ST_CLEAR && !dvp_set) |=>
      resp_valid && !halted_flag && state == vpen_pkg::ST_IDLE)
      else $error("enable sequence did not end with a cleared flag");

   // Main scenarios
   take_c: cover property (@(posedge pclk) disable iff (!presetn) take);
   full_c: cover property (@(posedge pclk) disable iff (!presetn)
      state == vpen_pkg::ST_WAKE ##1 state == vpen_pkg::ST_CLEAR ##1 !halted_flag);
   nop_c: cover property (@(posedge pclk) disable iff (!presetn) resp_valid && resp.nop);
   exc_c: cover property (@(posedge pclk) disable iff (!presetn)
      resp_valid && (resp.exc_cu || resp.exc_ri));
   deaf_c: cover property (@(posedge pclk) disable iff (!presetn)
      dvp_set && |(others(dvp_issuer) & wait_retired));
endmodule : vpen_unit
`default_nettype wire

// *** verif/test_virtual_processor_enable.sv ***
// Purpose: Self-checking bench for the virtual processor enable unit
// Assumes: Default four processors, zero-wait register bus
// Notes:   Instruction words are built from literal field values
`timescale 1ns/1ps
`default_nettype none
module test_virtual_processor_enable;
   logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic                 req_valid, req_ready, resp_valid, halted_flag, dvp_set, e;
   logic [11:0]          paddr;
   logic [31:0]          pwdata, prdata, q;
   logic [1:0]           req_issuer, dvp_issuer;
   logic [3:0]           pause_retired, wait_retired, load_link_flag, fetch_en, irq_en;
   vpen_pkg::vpen_req_t  req;
   vpen_pkg::vpen_resp_t resp;
   int                   error_cnt, check_count, rv_cnt, lat;
   logic [31:0]          cv [3] = '{32'h51, 32'h61, 32'h60};
   logic [3:0]           ev [3] = '{4'b0010, 4'b0100, 4'b1001};

   vpen_unit i_vpen_unit (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .req(req), .req_issuer(req_issuer),
      .req_valid(req_valid), .req_ready(req_ready), .resp(resp), .resp_valid(resp_valid),
      .dvp_set(dvp_set), .dvp_issuer(dvp_issuer), .pause_retired(pause_retired),
      .wait_retired(wait_retired), .load_link_flag(load_link_flag), .fetch_en(fetch_en),
      .irq_en(irq_en), .halted_flag(halted_flag));
   vpen_vp_model i_vpen_vp_model (.pclk(pclk), .dvp_set(dvp_set), .dvp_issuer(dvp_issuer),
      .pause_retired(pause_retired), .wait_retired(wait_retired),
      .load_link_flag(load_link_flag));

   // Clock of 4 ns
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // Answers counted to spot a refused request that was taken anyway
   always @(posedge pclk) begin
      if (resp_valid === 1'b1) rv_cnt++;
   end

   // Verdict and end of run
   task results;
      $display("errors %0d checks %0d", error_cnt, check_count);
      if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : results
   task hang(input string m);
      error_cnt++;
      $display("[ERR] %0t timeout %s", $time, m);
      results();
   endtask : hang
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t value %h expected %h", $time, got, exp);
      end
   endtask : chk
   task chk_resp(input vpen_pkg::vpen_resp_t exp);
      check_count++;
      if (resp !== exp) begin
         error_cnt++;
         $display("[ERR] %0t answer %h expected %h", $time, resp, exp);
      end
   endtask : chk_resp
   // Bus transfer: setup, then access until ready is sampled high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) hang("bus");
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk); // Idle edge so the next call never re-drives psel in this step
   endtask : apb
   task rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
      apb(1'b0, a, 32'h0);
      chk(q, x);
      chk(32'(e), 32'(xe));
   endtask : rd
   function automatic logic [31:0] word(input logic [4:0] src);
      return {6'h00, 5'h00, src, 10'h0e5, 6'h3c};
   endfunction : word
   // Instruction request, held until taken, then wait for the answer
   task exec(input logic [31:0] ins, input logic [2:0] f, input logic [1:0] who);
      int n;
      req <= {ins, f};
      req_issuer <= who;
      req_valid <= 1'b1;
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (req_ready !== 1'b1 && n < 20);
      if (n >= 20) hang("take");
      @(posedge pclk);
      req_valid <= 1'b0;
      lat = 0;
      do begin
         @(negedge pclk);
         lat++;
      end while (resp_valid !== 1'b1 && lat < 20);
      if (lat >= 20) hang("answer");
      @(posedge pclk);
   endtask : exec
   // Request that must never be taken
   task refuse(input logic [31:0] ins, input logic [2:0] f);
      int c;
      c = rv_cnt;
      req <= {ins, f};
      req_valid <= 1'b1;
      repeat (3) @(negedge pclk);
      chk(32'(req_ready), 32'h0);
      @(posedge pclk);
      req_valid <= 1'b0;
      @(posedge pclk);
      chk(32'(rv_cnt), 32'(c));
   endtask : refuse

   // Main sequence
   initial begin
      {presetn, psel, penable, pwrite, req_valid} = 5'h00;
      {paddr, pwdata, req, req_issuer} = '0;
      {error_cnt, check_count, rv_cnt} = '0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(12'h000, 32'h61, 1'b0);
      rd(12'h00c, 32'h0, 1'b0);
      rd(12'h010, 32'h0f0f, 1'b0);
      rd(12'h014, 32'h0, 1'b1);
      apb(1'b1, 12'h004, 32'h1);
      rd(12'h004, 32'h0, 1'b0);
      exec(word(5'd3), 3'b101, 2'd0);
      chk_resp({1'b1, 5'd3, 32'h0, 3'b001});
      chk(32'(lat), 32'd2);
      chk(32'(irq), 32'h0);
      i_vpen_vp_model.dvp(2'd1, 4'b1000, 4'b0100);
      @(negedge pclk);
      chk(32'(halted_flag), 32'h1);
      chk(32'(fetch_en), 32'h2);
      chk(32'(irq_en), 32'hb);
      @(posedge pclk);
      rd(12'h004, 32'h1, 1'b0);
      refuse(word(5'd0) ^ 32'h40, 3'b101);
      refuse(word(5'd0) | 32'h0020_0000, 3'b101);
      refuse(word(5'd0) ^ 32'h8000_0000, 3'b101);
      refuse(word(5'd0), 3'b001);
      refuse(word(5'd0), 3'b111);
      for (int k = 0; k < 3; k++) begin
         apb(1'b1, 12'h000, cv[k]);
         exec(word(5'd4), {2'b10, k != 1}, 2'd1);
         chk(32'({resp.gpr_we, resp.exc_cu, resp.exc_ri, resp.nop}), 32'(ev[k]));
         chk(32'(lat), 32'd2);
      end
      chk(32'(halted_flag), 32'h1);
      apb(1'b1, 12'h000, 32'h61);
      apb(1'b1, 12'h00c, 32'h1);
      i_vpen_vp_model.ll(4'b0111);
      exec(word(5'd5), 3'b101, 2'd1);
      chk_resp({1'b1, 5'd5, 32'h1, 3'b000});
      chk(32'(lat), 32'd4);
      chk(32'(halted_flag), 32'h0);
      chk(32'(fetch_en), 32'h7);
      chk(32'(irq_en), 32'hf);
      chk(32'(irq), 32'h1);
      rd(12'h008, 32'h1f, 1'b0);
      @(negedge pclk);
      chk(32'(irq), 32'h0);
      @(posedge pclk);
      rd(12'h008, 32'h0, 1'b0);
      rd(12'h004, 32'h0, 1'b0);
      i_vpen_vp_model.dvp(2'd0, 4'h0, 4'h0);
      exec(word(5'd0), 3'b101, 2'd0);
      chk(32'(resp.gpr_we), 32'h0);
      chk(32'(fetch_en), 32'hf);
      chk(32'(halted_flag), 32'h0);
      results();
   end
endmodule : test_virtual_processor_enable
`default_nettype wire

// *** verif/vpen_vp_model.sv ***
// Purpose: Other virtual processors of the core, as seen by the enable unit
// Assumes: Task calls start right after a rising clock edge
// Notes:   Issuer line is scrambled once the disable pulse is over
`timescale 1ns/1ps
`default_nettype none
module vpen_vp_model (
   input  wire logic  pclk,
   output logic       dvp_set,
   output logic [1:0] dvp_issuer,
   output logic [3:0] pause_retired,
   output logic [3:0] wait_retired,
   output logic [3:0] load_link_flag
);
   // Idle levels at time zero
   initial begin
      dvp_set = 1'b0;
      dvp_issuer = 2'h0;
      pause_retired = 4'h0;
      wait_retired = 4'h0;
      load_link_flag = 4'hf;
   end
   // One disable pulse; the bench always follows it with an enable
   task dvp(input logic [1:0] who, input logic [3:0] pz, input logic [3:0] wt);
      dvp_set <= 1'b1;
      dvp_issuer <= who;
      pause_retired <= pz;
      wait_retired <= wt;
      @(posedge pclk);
      dvp_set <= 1'b0;
      dvp_issuer <= ~who; // Stale issuer is not kept after the pulse
   endtask : dvp
   // Link flags of paused processors, cleared by remote stores
   task ll(input logic [3:0] v);
      load_link_flag <= v;
   endtask : ll
endmodule : vpen_vp_model
`default_nettype wire
